// >>> bench/fmcs_properties.sv
/*
  fmcs_properties: link checks between host and fan controller ends.
  assumes every wire is sampled on mclk_i and reset is synchronous.
*/
`timescale 1ns/100ps
module fmcs_properties
  import fmcs_pkg::*;
#(
  parameter int READY_CYC = 500
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic scl_host_o,
  input wire logic scl_host_oe,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic        scl_q, hoe_q, first_q, seen_q, start, rise;
  logic [3:0]  bit_q;
  logic [7:0]  sh_q;
  logic [15:0] rel_q;
  // start taken from the host's own pull, so feedback toggles never count
  assign start = scl & scl_q & sda_host_oe & ~hoe_q;
  assign rise  = scl & ~scl_q;
  always_ff @(posedge mclk_i) begin
    scl_q <= scl;
    hoe_q <= sda_host_oe;
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rel_q  <= 16'h0000;
      seen_q <= 1'b0;
    end else begin
      if (rel_q < 16'(READY_CYC)) rel_q <= rel_q + 16'h0001;
      if (start) seen_q <= 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      first_q <= 1'b0;
      bit_q   <= 4'h0;
      sh_q    <= 8'h00;
    end else if (start) begin
      first_q <= 1'b1;
      bit_q   <= 4'h0;
    end else if (rise && bit_q == 4'h8) begin
      first_q <= 1'b0;
      bit_q   <= 4'h0;
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end
  sequence s_addr_end;
    rise && bit_q == 4'h8 && first_q;
  endsequence
  a_ready_quiet: assert property (
    (rel_q < 16'(READY_CYC)) && !seen_q |-> !sda_dev_oe) else $error("feedback pulled early");
  a_addr_ack: assert property (
    s_addr_end ##0 (sh_q[7:1] == I2C_ADDR) |-> sda_dev_oe) else $error("own address not acked");
  a_addr_nak: assert property (
    s_addr_end ##0 (sh_q[7:1] != I2C_ADDR) |-> !sda_dev_oe) else $error("foreign address acked");
  a_start_free: assert property (
    start |-> !sda_dev_oe) else $error("start while feedback low");
  a_addr_stable: assert property (
    first_q && scl && scl_q |-> $stable(sda_host_oe)) else $error("data moved with clock high");
  a_ack_low_scl: assert property (
    first_q && $rose(sda_dev_oe) |-> !scl) else $error("device drove data with clock high");
  a_host_scl_on: assert property (
    $fell(sys_rst_i) |-> ##[0:2] scl_host_oe) else $error("command pin not driven");
  a_scl_kept: assert property (
    scl_host_oe |=> scl_host_oe) else $error("command pin dropped");
endmodule

// >>> bench/fmcs_test.sv
/*
  fmcs_test: host and fan controller joined by one link, driven from the
  host register port and the motor status inputs.
  assumes shortened standby, retry and ready counts.
*/
`timescale 1ns/100ps
module fmcs_test
  import fmcs_pkg::*;
;
  localparam int READY = 500;
  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0, rd = 1'b0;
  logic        tach = 1'b1, stat = 1'b0, lock = 1'b0, shrt = 1'b0;
  logic [10:0] phase = 11'h000;
  logic [15:0] rdata, got;
  logic [9:0]  amp;
  logic [10:0] spd;
  logic        den, lim, stby, flt, imode;
  int          fail_count = 0, n_compared = 0, cyc = 0;
  fmcs_link_if link ();
  fmcs_dev #(.STBY_CYC(200), .RETRY_CYC(300), .READY_CYC(READY)) fmcs_dev_i (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .link(link), .tach_i(tach),
    .stationary_i(stat), .lock_i(lock), .short_i(shrt), .phase_i(phase), .amp_o(amp),
    .speed_tgt_o(spd), .drive_en_o(den), .limit_o(lim), .standby_o(stby),
    .fault_o(flt), .i2c_mode_o(imode));
  fmcs_host fmcs_host_i (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .link(link));
  fmcs_properties #(.READY_CYC(READY)) fmcs_properties_i (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .scl_host_o(link.scl_host_o), .scl_host_oe(link.scl_host_oe),
    .sda_dev_oe(link.sda_dev_oe), .sda_host_oe(link.sda_host_oe), .scl(link.scl),
    .sda(link.sda));
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chkw(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(string nm, logic e, logic g);
    chkw(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic wr_reg(logic [2:0] a, logic [15:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [2:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk_i);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic do_reset();
    sys_rst_i <= 1'b1;
    tick(5);
    sys_rst_i <= 1'b0;
    wr_reg(H_PERIOD, 16'h0400); // about 9.8 kHz, rate select 0
  endtask
  task automatic serial(logic [1:0] op, logic [7:0] ptr, logic [15:0] d);
    wr_reg(H_DATA, d);
    wr_reg(H_PTR, {8'h00, ptr});
    wr_reg(H_OP, {14'h0000, op});
    got = 16'h0001;
    for (int i = 0; i < 3000 && got[0] !== 1'b0; i++) rd_reg(H_STAT);
    chkb("busy", 1'b0, got[0]);
    chkb("nack", 1'b0, got[1]);
  endtask
  // pointer is set before every read since the read transfer sends no pointer byte
  task automatic rd_word(logic [7:0] ptr, logic [15:0] e);
    serial(OP_PTR, ptr, 16'h0000);
    serial(OP_READ, ptr, 16'h0000);
    rd_reg(H_DATA);
    chkw("word", e, got);
  endtask
  task automatic t_feedback();
    tach <= 1'b0;
    tick(100);
    chkb("fb early", 1'b1, link.sda);
    tick(READY);
    chkb("fb low", 1'b0, link.sda);
    tach <= 1'b1;
    tick(5);
    chkb("fb high", 1'b1, link.sda);
  endtask
  task automatic t_ramp();
    wr_reg(H_HIGH, 16'h0064);
    tick(3000);
    chkb("ramp up", 1'b1, amp > 10'h000 && amp < 10'h064);
    for (int i = 0; i < 15000 && amp !== 10'h064; i++) tick(1);
    chkw("amp", 16'h0064, {6'h00, amp});
    wr_reg(H_HIGH, 16'h0046);
    tick(3000);
    chkb("hold", 1'b1, den);
    wr_reg(H_HIGH, 16'h0032);
    tick(3000);
    chkb("ramp down", 1'b1, amp > 10'h000 && amp < 10'h046);
    for (int i = 0; i < 12000 && amp !== 10'h000; i++) tick(1);
    chkb("stopped", 1'b0, den);
    wr_reg(H_HIGH, 16'h0046);
    tick(3000);
    chkb("no restart", 1'b0, den);
    wr_reg(H_HIGH, 16'h0064);
    for (int i = 0; i < 3000 && den !== 1'b1; i++) tick(1);
    chkb("restart", 1'b1, den);
  endtask
  task automatic t_faults();
    phase <= 11'h154;
    tick(5);
    chkb("limit on", 1'b1, lim);
    phase <= 11'h140;
    tick(5);
    chkb("limit off", 1'b0, lim);
    lock <= 1'b1;
    tick(5);
    lock <= 1'b0;
    chkb("lock off", 1'b0, den);
    tick(250);
    chkb("lock hold", 1'b0, den);
    for (int i = 0; i < 2000 && den !== 1'b1; i++) tick(1);
    chkb("lock retry", 1'b1, den);
    shrt <= 1'b1;
    tick(3);
    shrt <= 1'b0;
    chkb("short", 1'b1, flt & ~den);
    tick(400);
    chkb("short held", 1'b1, flt);
    wr_reg(H_HIGH, 16'h0032);
    for (int i = 0; i < 4000 && flt !== 1'b0; i++) tick(1);
    chkb("short clear", 1'b0, flt);
  endtask
  task automatic t_standby();
    stat <= 1'b1;
    wr_reg(H_HIGH, 16'h0000);
    for (int i = 0; i < 6000 && stby !== 1'b1; i++) tick(1);
    chkb("standby", 1'b1, stby);
    wr_reg(H_HIGH, 16'h0064);
    for (int i = 0; i < 2000 && stby !== 1'b0; i++) tick(1);
    chkb("wake", 1'b0, stby);
    stat <= 1'b0;
    tach <= 1'b0;
    tick(100);
    chkb("fb after wake", 1'b1, link.sda);
    tach <= 1'b1;
  endtask
  task automatic t_serial();
    do_reset();
    tick(20);
    rd_word(REG_SPEED, 16'h03e8);
    chkb("serial mode", 1'b1, imode);
    serial(OP_WRITE, REG_SPEED, 16'h0c00);
    rd_word(REG_SPEED, 16'h0c00);
    rd_word(NV_BASE, 16'h03e8);
    tach <= 1'b0;
    tick(20);
    chkb("fb dedicated", 1'b1, link.sda);
    serial(OP_WRITE, NV_BASE, 16'h0c00);
    do_reset();
    // low duty keeps the gradual ramp short: 80 steps at one per 101 cycles
    wr_reg(H_HIGH, 16'h0050);
    for (int i = 0; i < 12000 && spd !== 11'h050; i++) tick(1);
    chkw("target", 16'h0050, {5'h00, spd});
    chkw("amp closed", 16'h0000, {6'h00, amp});
  endtask
  initial begin
    do_reset();
    t_feedback();
    t_ramp();
    t_faults();
    t_standby();
    t_serial();
    complete_run();
  end
endmodule

// >>> design/fmcs_dev.sv
/*
  fan controller end: duty decode, on/off hysteresis, gradual ramps, standby,
  lock and short recovery, speed feedback and serial target with working
  registers shadowing the nonvolatile store.
  assumes motor-side status (tach, lock, short, stationary, phase current)
  arrives synchronous to mclk_i.
*/
// Implementation choice: strobed register access.
// Notes on behaviour
// RULE_01: open loop: amplitude follows duty.
// RULE_02: closed loop: speed target = rated times duty.
// RULE_03: host picks rate select by 2.8 kHz.
// RULE_04: command 80 Hz to 100 kHz decoded.
// RULE_05: stop below off, restart above on.
// RULE_06: standby after one second low, stationary.
// RULE_07: standby wakes on command rising edge.
// RULE_08: current ramps gently at on and off.
// RULE_09: speed reported on open-drain feedback.
// RULE_10: command pin is clock, feedback is data.
// RULE_11: first command only while feedback high.
// RULE_12: after first command, feedback line serves data.
// RULE_13: feedback released 9.8 ms after start or wake.
// RULE_14: host talks within 9.8 ms.
// RULE_15: locked rotor: off 5 s, then retry.
// RULE_16: current capped at 1.3 times rated.
// RULE_17: phase short stops drive at once.
// RULE_18: short clears by off/on, or 5 s timed.
// RULE_19: serial target address 0x55.
// RULE_20: nonvolatile defaults copied at power-on.
// RULE_21: register writes act at once; store programmable.
// RULE_22: register address is store address plus 64.
// RULE_23: duty = high time over period, per period.
`timescale 1ns/100ps
module fmcs_dev
  import fmcs_pkg::*;
#(
  parameter int STBY_CYC  = STBY_MS * MS_CYC,
  parameter int RETRY_CYC = RETRY_MS * MS_CYC,
  parameter int READY_CYC = READY_US * US_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  fmcs_link_if.dev         link,
  input  wire logic        tach_i,
  input  wire logic        stationary_i,
  input  wire logic        lock_i,
  input  wire logic        short_i,
  input  wire logic [10:0] phase_i,
  output logic      [9:0]  amp_o,
  output logic      [10:0] speed_tgt_o,
  output logic             drive_en_o,
  output logic             limit_o,
  output logic             standby_o,
  output logic             fault_o,
  output logic             i2c_mode_o
);
  logic [2:0]  scl_s, sda_s;
  logic [15:0] nv [8];
  logic [15:0] regs_q [8];
  logic [17:0] per_q, hi_q, tmo;
  logic [18:0] rem_q, rem2;
  logic [17:0] dvs_q;
  logic [9:0]  quo_q, duty_q, amp_q;
  logic [3:0]  div_n_q;
  logic        done_q, run_q, i2c_mode_q, sda_oe_q, mack_q, rw_q, ok_q, wr_q;
  logic [25:0] low_q, tmr_q, rdy_q;
  logic [15:0] step_q, wdat_q, tx_q, rd_word;
  logic [2:0]  ld_q;
  logic [3:0]  bit_q;
  logic [1:0]  byte_q, sel;
  logic [7:0]  sh_q, ptr_q, dhi_q;
  fmcs_mst_t   st_q;
  fmcs_ist_t   ist_q;
  logic        scl, sda, scl_rise, scl_fall, start, stop, rdy_done, fb_drv;
  logic        in_reg, in_nv;
  logic [20:0] spd_prod;
  logic [14:0] ph10, lim13;

  // the first stage is read by the second only
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], link.scl};
      sda_s <= {sda_s[1:0], link.sda};
    end
  end
  assign scl      = scl_s[1];
  assign sda      = sda_s[1];
  assign scl_rise = scl_s[1] & ~scl_s[2];
  assign scl_fall = ~scl_s[1] & scl_s[2];
  assign start    = sda_s[2] & ~sda_s[1] & scl;
  assign stop     = ~sda_s[2] & sda_s[1] & scl;
  assign sel      = regs_q[6][ONOFF_LSB +: 2];
  assign tmo      = regs_q[0][RATE_BIT] ? TMO1_CYC : TMO0_CYC;
  assign rdy_done = rdy_q == 26'(READY_CYC);
  assign fb_drv   = !i2c_mode_q && rdy_done && st_q != S_STBY && !tach_i;
  assign in_reg   = ptr_q[7:3] == REG_BASE[7:3];
  assign in_nv    = ptr_q[7:3] == NV_BASE[7:3];
  assign rd_word  = in_reg ? regs_q[ptr_q[2:0]] : (in_nv ? nv[ptr_q[2:0]] : 16'h0000);
  assign rem2     = {rem_q[17:0], 1'b0};

  // period and high time counters; a stuck line saturates at the timeout
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      per_q <= 18'h0;
      hi_q  <= 18'h0;
    end else if (scl_rise) begin // [RULE_23]
      per_q <= 18'h1;
      hi_q  <= 18'h1;
    end else if (per_q != tmo) begin // [RULE_04]
      per_q <= per_q + 18'h1;
      hi_q  <= hi_q + {17'h0, scl};
    end
  end

  // serial divider, ten quotient bits in ten cycles
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      div_n_q <= 4'h0;
      rem_q   <= 19'h0;
      dvs_q   <= 18'h0;
      quo_q   <= 10'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= div_n_q == 4'h1;
      if (scl_rise && !i2c_mode_q && per_q != 18'h0) begin // [RULE_23]
        dvs_q   <= per_q;
        rem_q   <= {1'b0, hi_q};
        div_n_q <= 4'ha;
        quo_q   <= 10'h0;
      end else if (div_n_q != 4'h0) begin
        div_n_q <= div_n_q - 4'h1;
        if (rem2 >= {1'b0, dvs_q}) begin
          rem_q <= rem2 - {1'b0, dvs_q};
          quo_q <= {quo_q[8:0], 1'b1};
        end else begin
          rem_q <= rem2;
          quo_q <= {quo_q[8:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      duty_q <= 10'h0;
    end else if (!i2c_mode_q && per_q == tmo) begin
      duty_q <= scl ? 10'h3ff : 10'h000;
    end else if (done_q) begin
      duty_q <= quo_q; // [RULE_23]
    end
  end

  // on/off hysteresis
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_q <= 1'b0;
    end else if (duty_q >= ON_TH[sel]) begin // [RULE_05]
      run_q <= 1'b1;
    end else if (duty_q < OFF_TH[sel]) begin // [RULE_05]
      run_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || scl) begin
      low_q <= 26'h0;
    end else if (low_q != 26'(STBY_CYC)) begin
      low_q <= low_q + 26'h1;
    end
  end

  // main state: load, idle, run, lock wait, short, standby
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_q  <= S_LOAD;
      ld_q  <= 3'h0;
      tmr_q <= 26'h0;
    end else begin
      tmr_q <= (st_q == S_LOCK || st_q == S_SHORT) ? tmr_q + 26'h1 : 26'h0;
      case (st_q)
        S_LOAD: begin
          ld_q <= ld_q + 3'h1;
          if (ld_q == 3'h7) st_q <= S_IDLE;
        end
        S_IDLE: begin
          if (run_q) st_q <= S_RUN;
          else if (low_q == 26'(STBY_CYC) && stationary_i) st_q <= S_STBY; // [RULE_06]
        end
        S_RUN: begin
          if (short_i) st_q <= S_SHORT; // [RULE_17]
          else if (lock_i) st_q <= S_LOCK;
          else if (!run_q) st_q <= S_IDLE;
        end
        S_LOCK: begin
          if (tmr_q == 26'(RETRY_CYC)) st_q <= S_IDLE; // [RULE_15]
        end
        S_SHORT: begin
          // clearing on command-off makes the next on a fresh start
          if (!run_q) st_q <= S_IDLE; // [RULE_18]
          else if (regs_q[6][TIMED_BIT] && tmr_q == 26'(RETRY_CYC)) st_q <= S_IDLE; // [RULE_18]
        end
        S_STBY: begin
          if (scl_rise) st_q <= S_IDLE; // [RULE_07]
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // feedback hold-off after power-on and after wake
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || st_q == S_STBY) begin
      rdy_q <= 26'h0;
    end else if (!rdy_done) begin
      rdy_q <= rdy_q + 26'h1; // [RULE_13]
    end
  end

  // gradual ramp; protection paths bypass it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      amp_q  <= 10'h0;
      step_q <= 16'h0;
    end else if (short_i || st_q != S_RUN && st_q != S_IDLE) begin
      amp_q  <= 10'h0; // [RULE_17] [RULE_15]
      step_q <= 16'h0;
    end else begin
      step_q <= (step_q == RAMP_CYC) ? 16'h0 : step_q + 16'h1;
      if (st_q == S_RUN && amp_q < duty_q) begin
        if (!regs_q[7][SON_BIT]) amp_q <= duty_q;
        else if (step_q == RAMP_CYC) amp_q <= amp_q + 10'h1; // [RULE_08]
      end else if (amp_q > duty_q || st_q != S_RUN && amp_q != 10'h0) begin
        if (!regs_q[7][SOFF_BIT]) amp_q <= st_q == S_RUN ? duty_q : 10'h0;
        else if (step_q == RAMP_CYC) amp_q <= amp_q - 10'h1; // [RULE_08]
      end
    end
  end

  assign spd_prod = regs_q[0][SPD_W-1:0] * amp_q;
  assign ph10     = {phase_i, 3'h0} + {3'h0, phase_i, 1'b0};
  assign lim13    = 15'(regs_q[2][SPD_W-1:0] * 4'hd);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      amp_o       <= 10'h0;
      speed_tgt_o <= 11'h0;
      drive_en_o  <= 1'b0;
      limit_o     <= 1'b0;
      standby_o   <= 1'b0;
      fault_o     <= 1'b0;
    end else begin
      amp_o       <= regs_q[0][CL_BIT] ? 10'h0 : amp_q; // [RULE_01]
      speed_tgt_o <= regs_q[0][CL_BIT] ? spd_prod[20:10] : 11'h0; // [RULE_02]
      drive_en_o  <= st_q == S_RUN && !short_i;
      limit_o     <= ph10 > lim13; // [RULE_16]
      standby_o   <= st_q == S_STBY;
      fault_o     <= st_q == S_SHORT;
    end
  end

  // serial target on the shared pins
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      ist_q <= I_IDLE;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      sh_q <= 8'h0;
      ptr_q <= 8'h0;
      dhi_q <= 8'h0;
      tx_q <= 16'h0;
      rw_q <= 1'b0;
      ok_q <= 1'b0;
      mack_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= 16'h0;
      i2c_mode_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      if (stop) begin
        ist_q <= I_IDLE;
        ok_q  <= 1'b0;
        if (ok_q) i2c_mode_q <= 1'b1; // [RULE_12]
      end else if (start && !fb_drv && !sda_oe_q) begin // [RULE_11] [RULE_10]
        ist_q  <= I_RX;
        bit_q  <= 4'h0;
        byte_q <= 2'h0;
      end else begin
        case (ist_q)
          I_RX: begin
            if (scl_rise) begin
              sh_q  <= {sh_q[6:0], sda};
              bit_q <= bit_q + 4'h1;
            end else if (scl_fall && bit_q == 4'h8) begin
              ist_q <= I_ACK;
              if (byte_q == 2'h0) begin
                if (sh_q[7:1] != I2C_ADDR) ist_q <= I_IDLE; // [RULE_19]
                rw_q <= sh_q[0];
                ok_q <= sh_q[7:1] == I2C_ADDR;
                tx_q <= rd_word;
              end else if (byte_q == 2'h1) begin
                ptr_q <= sh_q;
              end else if (byte_q == 2'h2) begin
                dhi_q <= sh_q;
              end else begin
                wr_q   <= 1'b1; // [RULE_21]
                wdat_q <= {dhi_q, sh_q};
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              bit_q  <= 4'h0;
              byte_q <= (byte_q == 2'h3) ? 2'h3 : byte_q + 2'h1;
              ist_q  <= rw_q ? I_TX : I_RX;
            end
          end
          I_TX: begin
            if (scl_fall) begin
              tx_q  <= {tx_q[14:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h7) ist_q <= I_MACK;
            end
          end
          I_MACK: begin
            if (scl_rise) mack_q <= sda;
            if (scl_fall) begin
              bit_q <= 4'h0;
              ist_q <= mack_q ? I_IDLE : I_TX;
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= ist_q == I_ACK || ist_q == I_TX && !tx_q[15] || fb_drv; // [RULE_09]
    end
  end
  assign link.sda_dev_oe = sda_oe_q;
  assign i2c_mode_o      = i2c_mode_q;

  // working registers: copied from the store after reset, then live
  always_ff @(posedge mclk_i) begin
    if (st_q == S_LOAD) begin
      regs_q[ld_q] <= nv[ld_q]; // [RULE_20]
    end else if (wr_q && in_reg) begin
      regs_q[ptr_q[2:0]] <= wdat_q; // [RULE_21] [RULE_22]
    end
  end

  // the store keeps its content across reset; it is seeded once
  initial begin
    for (int i = 0; i < 8; i++) nv[i] = NV_DEF[i];
  end
  always_ff @(posedge mclk_i) begin
    if (wr_q && in_nv) nv[ptr_q[2:0]] <= wdat_q; // [RULE_21]
  end
endmodule

// >>> design/fmcs_host.sv
/*
  host end: speed command generator and serial controller on the same pin.
  assumes a register master on the plain port; reads return next cycle.
*/
`timescale 1ns/100ps
module fmcs_host
  import fmcs_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  fmcs_link_if.host        link
);
  logic [15:0] per_q, high_q, cnt_q, dat_q, rx_q;
  logic [7:0]  ptr_q, b_q [4];
  logic [1:0]  ph_q, nb_q, byi_q;
  logic [4:0]  q_q;
  logic [3:0]  bit_q;
  logic        rxop_q, nack_q, scl_q, sda_oe_q, oe_q, tick, sda_s1, sda_s2;
  fmcs_hst_t   st_q;

  assign tick = q_q == 5'(I2C_QTR - 1);

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      per_q <= 16'h0;
      high_q <= 16'h0;
      ptr_q <= 8'h0;
      dat_q <= 16'h0;
      rdata_o <= 16'h0;
    end else begin
      rdata_o <= 16'h0;
      if (wr_i && addr_i == H_PERIOD) per_q <= wdata_i;
      if (wr_i && addr_i == H_HIGH) high_q <= wdata_i;
      if (wr_i && addr_i == H_PTR) ptr_q <= wdata_i[7:0];
      if (wr_i && addr_i == H_DATA) dat_q <= wdata_i;
      if (rd_i) begin
        case (addr_i)
          H_PERIOD: rdata_o <= per_q;
          H_HIGH:   rdata_o <= high_q;
          H_PTR:    rdata_o <= {8'h0, ptr_q};
          H_DATA:   rdata_o <= rx_q;
          H_STAT:   rdata_o <= {14'h0, nack_q, st_q != M_IDLE};
          default:  rdata_o <= 16'h0;
        endcase
      end
    end
  end

  // command waveform from a counter; keep rate select matched to its frequency
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || cnt_q + 16'h1 >= per_q) cnt_q <= 16'h0;
    else cnt_q <= cnt_q + 16'h1;
  end

  // serial engine: each bit is four quarter periods
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_q <= M_IDLE;
      q_q <= 5'h0;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byi_q <= 2'h0;
      nb_q <= 2'h0;
      rxop_q <= 1'b0;
      nack_q <= 1'b0;
      rx_q <= 16'h0;
      scl_q <= 1'b1;
      sda_oe_q <= 1'b0;
      oe_q <= 1'b0;
      for (int i = 0; i < 4; i++) b_q[i] <= 8'h0;
    end else begin
      oe_q <= 1'b1;
      q_q <= (st_q == M_IDLE || tick) ? 5'h0 : q_q + 5'h1;
      if (st_q != M_IDLE && tick) ph_q <= ph_q + 2'h1;
      case (st_q)
        M_IDLE: begin
          scl_q <= cnt_q < high_q;
          sda_oe_q <= 1'b0;
          ph_q <= 2'h0;
          if (wr_i && addr_i == H_OP) begin
            st_q <= M_START;
            nack_q <= 1'b0;
            rxop_q <= wdata_i[1:0] == OP_READ;
            b_q[0] <= {I2C_ADDR, wdata_i[1:0] == OP_READ};
            b_q[1] <= ptr_q;
            b_q[2] <= dat_q[15:8];
            b_q[3] <= dat_q[7:0];
            nb_q <= wdata_i[1:0] == OP_WRITE ? 2'h3 : 2'h2 - {1'b0, wdata_i[1:0] == OP_PTR};
          end
        end
        M_START: begin
          if (ph_q == 2'h0) scl_q <= 1'b1;
          if (ph_q == 2'h1) sda_oe_q <= 1'b1;
          if (ph_q == 2'h3) scl_q <= 1'b0;
          if (ph_q == 2'h3 && tick) begin
            st_q <= M_BIT;
            bit_q <= 4'h0;
            byi_q <= 2'h0;
          end
        end
        M_BIT: begin
          if (ph_q == 2'h0) begin
            if (bit_q == 4'h8) sda_oe_q <= rxop_q && byi_q != 2'h0 && byi_q != nb_q;
            else if (rxop_q && byi_q != 2'h0) sda_oe_q <= 1'b0;
            else sda_oe_q <= !b_q[byi_q][3'(7 - bit_q)];
          end
          if (ph_q == 2'h1) scl_q <= 1'b1;
          if (ph_q == 2'h2 && tick) begin
            if (bit_q != 4'h8 && rxop_q && byi_q != 2'h0) rx_q <= {rx_q[14:0], sda_s2};
            if (bit_q == 4'h8 && (!rxop_q || byi_q == 2'h0) && sda_s2) nack_q <= 1'b1;
          end
          if (ph_q == 2'h3) scl_q <= 1'b0;
          if (ph_q == 2'h3 && tick) begin
            bit_q <= bit_q == 4'h8 ? 4'h0 : bit_q + 4'h1;
            if (bit_q == 4'h8) byi_q <= byi_q + 2'h1;
            if (bit_q == 4'h8 && (byi_q == nb_q || nack_q)) st_q <= M_STOP;
          end
        end
        M_STOP: begin
          if (ph_q == 2'h0) sda_oe_q <= 1'b1;
          if (ph_q == 2'h1) scl_q <= 1'b1;
          if (ph_q == 2'h2) sda_oe_q <= 1'b0;
          if (ph_q == 2'h3 && tick) st_q <= M_IDLE;
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end

  assign link.scl_host_o  = scl_q;
  assign link.scl_host_oe = oe_q;
  assign link.sda_host_oe = sda_oe_q;
endmodule

// >>> design/fmcs_link_if.sv
/*
  two-pin link between host and fan controller: speed command / serial clock
  and open-drain speed feedback / serial data.
  assumes pull-ups on both wires; nobody driving reads as high.
*/
`timescale 1ns/100ps
interface fmcs_link_if;
  logic scl_host_o;
  logic scl_host_oe;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic scl;
  logic sda;
  assign scl = scl_host_oe ? scl_host_o : 1'b1;
  assign sda = ~(sda_dev_oe | sda_host_oe);
  modport dev  (input scl, input sda, output sda_dev_oe);
  modport host (input scl, input sda, output scl_host_o, output scl_host_oe,
                output sda_host_oe);
endinterface

// >>> design/fmcs_pkg.sv
/*
  shared constants of the fan motor command supervisor: timing, thresholds,
  serial-port map and host command port map.
  assumes a 10 MHz system clock on both ends.
*/
package fmcs_pkg;
  localparam int CLK_NS    = 100;
  localparam int MS_CYC    = 1000000 / CLK_NS;
  localparam int US_CYC    = 1000 / CLK_NS;
  localparam int STBY_MS   = 1000;
  localparam int RETRY_MS  = 5000;
  localparam int READY_US  = 9800;
  localparam int TMO0_US   = 400;
  localparam int TMO1_US   = 12500;
  localparam logic [17:0] TMO0_CYC = 18'(TMO0_US * US_CYC);
  localparam logic [17:0] TMO1_CYC = 18'(TMO1_US * US_CYC);
  localparam logic [15:0] RAMP_CYC = 16'h0064;
  localparam logic [6:0]  I2C_ADDR = 7'h55;
  localparam logic [7:0]  NV_OFS   = 8'h40;
  localparam logic [7:0]  NV_BASE  = 8'h08;
  localparam logic [7:0]  REG_BASE = NV_BASE + NV_OFS;
  localparam logic [7:0]  REG_SPEED = 8'h48;
  localparam logic [7:0]  REG_CURR  = 8'h4a;
  localparam logic [7:0]  REG_AUX   = 8'h4e;
  localparam logic [7:0]  REG_RAMP  = 8'h4f;
  localparam int SPD_W       = 11;
  localparam int CL_BIT      = 11;
  localparam int RATE_BIT    = 15;
  localparam int SON_BIT     = 7;
  localparam int SOFF_BIT    = 6;
  localparam int ONOFF_LSB   = 0;
  localparam int TIMED_BIT   = 2;
  localparam logic [15:0] NV_DEF [8] = '{16'h03e8, 16'h0000, 16'h0100, 16'h0000,
                                         16'h0000, 16'h0000, 16'h0000, 16'h00c0};
  localparam logic [9:0] ON_TH  [4] = '{10'h050, 10'h078, 10'h099, 10'h0dc};
  localparam logic [9:0] OFF_TH [4] = '{10'h03c, 10'h064, 10'h084, 10'h0c9};
  localparam int I2C_QTR = 25;
  localparam logic [2:0] H_PERIOD = 3'h0;
  localparam logic [2:0] H_HIGH   = 3'h1;
  localparam logic [2:0] H_PTR    = 3'h2;
  localparam logic [2:0] H_DATA   = 3'h3;
  localparam logic [2:0] H_OP     = 3'h4;
  localparam logic [2:0] H_STAT   = 3'h5;
  localparam logic [1:0] OP_WRITE = 2'h0;
  localparam logic [1:0] OP_PTR   = 2'h1;
  localparam logic [1:0] OP_READ  = 2'h2;
  typedef enum logic [2:0] {S_LOAD, S_IDLE, S_RUN, S_LOCK, S_SHORT, S_STBY} fmcs_mst_t;
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_MACK} fmcs_ist_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} fmcs_hst_t;
endpackage
